// >>> dv/acalo_mem_model.sv
// acalo_mem_model: data memory seen by the datapath, 128 bytes.
// assumes write-back requests arrive on i_clk; read is combinational.
`timescale 1ns/10ps
`default_nettype none
module acalo_mem_model (
  input  wire logic                  i_clk,
  input  wire logic [7:0]            i_addr,
  input  wire acalo_pkg::acalo_mem_wr_t i_wr,
  output logic      [7:0]            o_rdata
);
  import acalo_pkg::*;
  logic [7:0] mem_q [128];
  // known pattern so reads are never a leftover value
  initial begin
    for (int k = 0; k < 128; k++) mem_q[k] = 8'(k * 37 + 5);
  end
  // seven-bit select
  // forwarding keeps back-to-back requests on the newest byte
  assign o_rdata = (i_wr.we && i_wr.addr == i_addr[6:0]) ? i_wr.wdata : mem_q[i_addr[6:0]];
  always @(posedge i_clk) begin
    if (i_wr.we) mem_q[i_wr.addr] <= i_wr.wdata;
  end
endmodule : acalo_mem_model
`default_nettype wire

// >>> dv/add_carry_and_logic_ops_bench.sv
// add_carry_and_logic_ops_bench: random requests checked against a model.
// assumes acalo_datapath and acalo_mem_model; one clock of 4 ns.
`timescale 1ns/10ps
`default_nettype none
module add_carry_and_logic_ops_bench;
  import acalo_pkg::*;
  logic          i_clk, i_reset_n, i_valid, i_dest, i_flags_wr, o_done;
  acalo_op_t     i_op, s_op;
  logic [7:0]    i_addr, i_literal, rdata, o_acc, s_a, s_l;
  acalo_flags_t  i_flags_wdata, o_flags, fl, nf, s_fwd;
  acalo_mem_wr_t o_mem_wr;
  logic          s_v, s_d, s_fw;
  int            n_mismatch, n_checks, seed, acc, mem [128], e_done, e_we, e_addr, e_wd;
  acalo_datapath i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_valid(i_valid), .i_op(i_op),
    .i_dest(i_dest), .i_addr(i_addr), .i_literal(i_literal), .i_mem_rdata(rdata),
    .i_flags_wr(i_flags_wr), .i_flags_wdata(i_flags_wdata), .o_acc(o_acc), .o_flags(o_flags),
    .o_mem_wr(o_mem_wr), .o_done(o_done));
  acalo_mem_model i_mem (.i_clk(i_clk), .i_addr(i_addr), .i_wr(o_mem_wr), .o_rdata(rdata));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (exp !== got) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // one cycle: model the request taken at this edge, drive the next, compare
  task automatic step(input bit idle);
    int m, r, s;
    logic [31:0] rnd;
    @(posedge i_clk);
    nf = s_fw ? s_fwd : fl;
    e_done = 0;
    e_we = 0;
    if (s_v && s_op != ACALO_OP_NONE) begin
      e_done = 1;
      m = mem[s_a[6:0]];
      s = acc + m + fl.carry;
      r = (s_op == ACALO_OP_ADD_MC) ? s % 256 : (s_op == ACALO_OP_AND_LIT) ? (acc & s_l) : (acc & m);
      if (s_op == ACALO_OP_ADD_MC) begin
        nf.carry = s > 255;
        nf.digit_carry_flag = (acc % 16 + m % 16 + fl.carry) > 15;
      end
      nf.zero = (r == 0);
      if (s_op == ACALO_OP_AND_LIT || s_d == ACALO_DEST_ACC) acc = r;
      else begin
        mem[s_a[6:0]] = r;
        e_we = 1;
        e_addr = s_a[6:0];
        e_wd = r;
      end
    end
    fl = nf;
    rnd = $random(seed);
    s_v = !idle && (rnd[0] | rnd[1]);
    s_op = acalo_op_t'(rnd[3:2]);
    s_d = rnd[4];
    s_fw = !idle && rnd[7:5] == 3'h0;
    s_fwd = rnd[10:8];
    s_a = rnd[18:11];
    s_l = rnd[20] ? 8'hff : rnd[28:21];
    i_valid <= s_v;
    i_op <= s_op;
    i_dest <= s_d;
    i_flags_wr <= s_fw;
    i_flags_wdata <= s_fwd;
    i_addr <= s_a;
    i_literal <= s_l;
    #1;
    chk("done", 16'(e_done), 16'(o_done));
    chk("acc", 16'(acc), 16'(o_acc));
    chk("flags", 16'(fl), 16'(o_flags));
    chk("we", 16'(e_we), 16'(o_mem_wr.we));
    if (e_we) chk("addr", 16'(e_addr), 16'(o_mem_wr.addr));
    if (e_we) chk("wdata", 16'(e_wd), 16'(o_mem_wr.wdata));
  endtask : step
  // reset, random traffic, a reset in mid-run, more traffic
  initial begin
    seed = 6970;
    {i_reset_n, i_valid, i_dest, i_flags_wr, s_v, s_d, s_fw} = '0;
    {i_addr, i_literal, s_a, s_l, i_flags_wdata, s_fwd, fl} = '0;
    i_op = ACALO_OP_NONE;
    s_op = ACALO_OP_NONE;
    acc = 0;
    for (int k = 0; k < 128; k++) mem[k] = (k * 37 + 5) % 256;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int n = 0; n < 700; n++) step(n >= 698);
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      #1;
      chk("rst_acc", 16'h0000, 16'(o_acc));
      chk("rst_flags", 16'h0000, 16'(o_flags));
      chk("rst_done", 16'h0000, 16'({o_done, o_mem_wr.we}));
      acc = 0;
      fl = ACALO_FLAGS_RST;
      @(posedge i_clk);
      i_reset_n <= 1'b1;
    end
    give_verdict();
  end
endmodule : add_carry_and_logic_ops_bench
`default_nettype wire

// >>> src/acalo_datapath.sv
// acalo_datapath: execution datapath for add-with-carry and the two AND instructions.
// assumes the decoder presents one request per cycle with the memory operand already
// read (i_mem_rdata valid in the request cycle), all on i_clk.
// the upper address bit is dropped, so an operand above 7fh aliases onto 00h..7fh;
// code that expects a full 8-bit data space will see wrapped accesses.
//
// Summary of operation
// - add accumulator, memory operand and carry flag in one cycle.
// - destination bit 0 writes accumulator, 1 writes back to memory.
// - and accumulator with an 8-bit literal, result into accumulator.
// - and accumulator with memory operand, result routed by destination bit.
// - memory operand address selects a location within 00h to 7fh.
`timescale 1ns/10ps
`default_nettype none

module acalo_datapath (
  input  wire logic                                i_clk,
  input  wire logic                                i_reset_n,
  input  wire logic                                i_valid,
  input  wire acalo_pkg::acalo_op_t                i_op,
  input  wire logic                                i_dest,
  input  wire logic [7:0]                          i_addr,
  input  wire logic [acalo_pkg::ACALO_DATA_W-1:0]  i_literal,
  input  wire logic [acalo_pkg::ACALO_DATA_W-1:0]  i_mem_rdata,
  input  wire logic                                i_flags_wr,
  input  wire acalo_pkg::acalo_flags_t             i_flags_wdata,
  output logic      [acalo_pkg::ACALO_DATA_W-1:0]  o_acc,
  output acalo_pkg::acalo_flags_t                  o_flags,
  output acalo_pkg::acalo_mem_wr_t                 o_mem_wr,
  output logic                                     o_done
);
  import acalo_pkg::*;

  logic [ACALO_DATA_W-1:0] acc_q;
  logic [ACALO_DATA_W-1:0] acc_d;
  acalo_flags_t            flags_q;
  acalo_flags_t            flags_d;
  acalo_mem_wr_t           mem_wr_q;
  acalo_mem_wr_t           mem_wr_d;
  logic                    done_q;
  logic                    done_d;

  logic [ACALO_DATA_W:0]   sum9;
  logic [ACALO_NIB_W:0]    sum_nib;
  logic [ACALO_DATA_W-1:0] result;
  logic                    is_mem_op;

  // zero test used by every executed instruction's flag update
  function automatic logic acalo_is_zero(input logic [ACALO_DATA_W-1:0] val);
    return val == ACALO_ZERO_VAL;
  endfunction : acalo_is_zero

  // arithmetic and logic results, computed every cycle
  always_comb begin
    sum9    = {1'b0, acc_q} + {1'b0, i_mem_rdata} + {{ACALO_DATA_W{1'b0}}, flags_q.carry};
    sum_nib = {1'b0, acc_q[ACALO_NIB_W-1:0]} + {1'b0, i_mem_rdata[ACALO_NIB_W-1:0]}
              + {{ACALO_NIB_W{1'b0}}, flags_q.carry};
    case (i_op)
      ACALO_OP_ADD_MC:  result = sum9[ACALO_DATA_W-1:0];
      ACALO_OP_AND_LIT: result = acc_q & i_literal;
      ACALO_OP_AND_MEM: result = acc_q & i_mem_rdata;
      default:          result = acc_q;
    endcase
    is_mem_op = (i_op == ACALO_OP_ADD_MC) || (i_op == ACALO_OP_AND_MEM);
  end

  // next state of accumulator, flags and write-back request
  always_comb begin
    acc_d    = acc_q;
    flags_d  = flags_q;
    mem_wr_d = ACALO_MEM_WR_RST;
    done_d   = 1'b0;
    // the core may load the flags; an executing instruction overrides the zero bit of that load, an add also carry and digit carry
    if (i_flags_wr) begin
      flags_d = i_flags_wdata;
    end
    if (i_valid && (i_op != ACALO_OP_NONE)) begin
      done_d = 1'b1;
      flags_d.zero = acalo_is_zero(result);
      if (i_op == ACALO_OP_ADD_MC) begin
        flags_d.carry            = sum9[ACALO_DATA_W];
        flags_d.digit_carry_flag = sum_nib[ACALO_NIB_W];
      end
      if (is_mem_op && (i_dest == ACALO_DEST_MEM)) begin
        mem_wr_d.we    = 1'b1;
        // upper address bit dropped, stays in 00h..7fh
        mem_wr_d.addr  = i_addr[ACALO_ADDR_W-1:0];
        mem_wr_d.wdata = result;
      end else begin
        acc_d = result;
      end
    end
  end

  // state registers; one-cycle latency from request to result
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_q    <= ACALO_ACC_RST;
      flags_q  <= ACALO_FLAGS_RST;
      mem_wr_q <= ACALO_MEM_WR_RST;
      done_q   <= 1'b0;
    end else begin
      acc_q    <= acc_d;
      flags_q  <= flags_d;
      mem_wr_q <= mem_wr_d;
      done_q   <= done_d;
    end
  end

  // outputs straight from flops
  assign o_acc    = acc_q;
  assign o_flags  = flags_q;
  assign o_mem_wr = mem_wr_q;
  assign o_done   = done_q;

  // checks on the datapath behaviour
  default clocking acalo_cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence seq_add_req;
    i_valid && (i_op == ACALO_OP_ADD_MC);
  endsequence

  sequence seq_andm_req;
    i_valid && (i_op == ACALO_OP_AND_MEM);
  endsequence

  sequence seq_andl_req;
    i_valid && (i_op == ACALO_OP_AND_LIT);
  endsequence

  // request kinds used by the checks below
  sequence seq_exec_req;
    i_valid && (i_op != ACALO_OP_NONE);
  endsequence

  sequence seq_memop_acc;
    i_valid && ((i_op == ACALO_OP_ADD_MC) || (i_op == ACALO_OP_AND_MEM)) && (i_dest == ACALO_DEST_ACC);
  endsequence

  sequence seq_memop_mem;
    i_valid && ((i_op == ACALO_OP_ADD_MC) || (i_op == ACALO_OP_AND_MEM)) && (i_dest == ACALO_DEST_MEM);
  endsequence

  sequence seq_and_req;
    i_valid && ((i_op == ACALO_OP_AND_LIT) || (i_op == ACALO_OP_AND_MEM));
  endsequence

  sequence seq_flag_load;
    i_flags_wr && !(i_valid && (i_op != ACALO_OP_NONE));
  endsequence

  add_sum_a: assert property (seq_add_req ##1 1'b1 |->
    ({o_flags.carry, (o_mem_wr.we ? o_mem_wr.wdata : o_acc)}
      == ({1'b0, $past(acc_q)} + {1'b0, $past(i_mem_rdata)} + {8'h00, $past(flags_q.carry)})))
    else $error("add result or carry wrong");

  dest_acc_a: assert property (seq_memop_acc |=> !o_mem_wr.we && o_done)
    else $error("dest 0 wrote memory");

  dest_mem_a: assert property (seq_memop_mem |=> o_mem_wr.we && $stable(o_acc))
    else $error("dest 1 routed wrong");

  and_lit_a: assert property (seq_andl_req |=>
    (o_acc == ($past(acc_q) & $past(i_literal))) && !o_mem_wr.we)
    else $error("and literal wrong");

  and_mem_a: assert property (seq_andm_req ##1 1'b1 |->
    ((o_mem_wr.we ? o_mem_wr.wdata : o_acc) == ($past(acc_q) & $past(i_mem_rdata))))
    else $error("and memory wrong");

  addr_range_a: assert property (seq_memop_mem |=>
    o_mem_wr.addr == $past(i_addr[6:0]))
    else $error("write-back address wrong");

  // zero flag follows the result and carry holds on and
  zero_flag_a: assert property (seq_and_req |=>
    (o_flags.zero == ((o_mem_wr.we ? o_mem_wr.wdata : o_acc) == 8'h00))
    && (o_flags.carry == $past(i_flags_wr ? i_flags_wdata.carry : flags_q.carry)))
    else $error("and flag update wrong");

  // idle cycles produce nothing
  idle_quiet_a: assert property (!i_valid |=> !o_done && !o_mem_wr.we)
    else $error("output without request");

  // every executed request answers one cycle later
  done_pulse_a: assert property (seq_exec_req |=> o_done)
    else $error("executed request gave no done");

  // digit carry and zero after an add
  add_flags_a: assert property (seq_add_req |=>
    (o_flags.digit_carry_flag == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(i_mem_rdata[3:0])}
      + {4'h0, $past(flags_q.carry)}) > 5'h0f))
    && (o_flags.zero == ((o_mem_wr.we ? o_mem_wr.wdata : o_acc) == 8'h00)))
    else $error("add flag update wrong");

  and_dc_hold_a: assert property (seq_and_req |=>
    o_flags.digit_carry_flag == $past(i_flags_wr ? i_flags_wdata.digit_carry_flag : flags_q.digit_carry_flag))
    else $error("and touched digit carry");

  // a flag load with no instruction executing takes the written value whole
  flag_load_a: assert property (seq_flag_load |=> o_flags == $past(i_flags_wdata))
    else $error("flag load lost");

  // cycles without a request keep the accumulator
  acc_hold_a: assert property (!i_valid |=> $stable(o_acc))
    else $error("accumulator changed while idle");

endmodule : acalo_datapath

`default_nettype wire

// >>> src/acalo_pkg.sv
// acalo_pkg: shared constants and types for the add-with-carry / AND datapath.
// assumes an 8-bit core whose decoder and data memory run on the same clock.
package acalo_pkg;

  // datapath widths
  localparam int unsigned ACALO_DATA_W = 8;
  localparam int unsigned ACALO_ADDR_W = 7;  // data memory spans 00h..7fh

  // reset value and zero-test constant
  localparam logic [ACALO_DATA_W-1:0] ACALO_ACC_RST  = 8'h00;
  localparam logic [ACALO_DATA_W-1:0] ACALO_ZERO_VAL = 8'h00;

  // destination-select encoding for memory-operand instructions
  localparam logic ACALO_DEST_ACC = 1'b0;
  localparam logic ACALO_DEST_MEM = 1'b1;

  // position of the nibble boundary for the digit carry
  localparam int unsigned ACALO_NIB_W = 4;

  // operations executed by this datapath
  typedef enum logic [1:0] {
    ACALO_OP_NONE    = 2'h0,
    ACALO_OP_ADD_MC  = 2'h1,  // add_acc_mem_carry
    ACALO_OP_AND_LIT = 2'h3,  // and_acc_literal
    ACALO_OP_AND_MEM = 2'h2   // and_acc_mem
  } acalo_op_t;

  // status flags carried together
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } acalo_flags_t;

  localparam acalo_flags_t ACALO_FLAGS_RST = '{carry: 1'b0, digit_carry_flag: 1'b0, zero: 1'b0};

  // memory write-back request
  typedef struct packed {
    logic                    we;
    logic [ACALO_ADDR_W-1:0] addr;
    logic [ACALO_DATA_W-1:0] wdata;
  } acalo_mem_wr_t;

  localparam acalo_mem_wr_t ACALO_MEM_WR_RST = '{we: 1'b0, addr: 7'h00, wdata: 8'h00};

endpackage : acalo_pkg
